// ===== clock_divider_switchback_ctrl.sv
// system clock divider, switchback and ring oscillator resume control
//
// Overview of operation
// R1: pmm forms each system cycle from 1024 clocks
// R2: pmm entry or exit only via divide-by-1
// R3: illegal divider write ignored, bits kept
// R4: software checks serial idle before changing
// R5: timers reset to 12 clocks, selectable faster
// R6: pmm timer and baud tick periods
// R7: pmm serial mode 0 and 2 periods
// R8: switchback forces divide-by-1 when enabled
// R9: only acknowledged interrupts cause switchback
// R10: interrupts, serial, resets are switchback sources
// R11: receive switchback on start edge, receiver enabled
// R12: transmit buffer load causes switchback
// R13: serial interrupt flags never affect switchback
// R14: interrupt switchback at next system cycle
// R15: enable or priority write delays interrupts
// R16: transmit at next instruction, receive immediately
// R17: unmatched multiprocessor address still switches back
// R18: stop resume on ring, crystal after warm-up
// R19: read-only ring active flag, reset zero
// R20: power-on reset starts on crystal
// R21: stop mode uses true edge interrupt detection
// R22: divider decode, reset value divide-by-1
// R23: switchback enable resets zero, disables switchback
// R24: read-only serial activity flags, reset zero
// R25: divider changes only at cycle boundary; switchback loads divide-by-1 at once
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
`include "clkctl_defs.svh"
module clock_divider_switchback_ctrl #(
  parameter int WARMUP = `WARMUP_CLOCKS  // crystal warm-up clocks
) (
  input wire logic mclk,
  input wire logic rst,
  input wire clkctl_pkg::reg_req_t bus,
  output logic [7:0] rdata,
  input wire logic [5:0] ext_int_pin,
  input wire logic irq_ack,
  input wire logic ie_ip_write,
  input wire logic instr_end,
  input wire logic [1:0] rx_pin,
  input wire clkctl_pkg::serial_info_t serial,
  input wire logic reset_source,
  input wire logic stop_mode,
  input wire logic stop_exit,
  input wire logic xtal_pin,
  output logic sys_en,
  output clkctl_pkg::tick_t ticks,
  output logic [5:0] ext_int_edge,
  output logic ring_osc_select
);
  // software-visible state
  logic [1:0] divider;  // divider_select_hi/lo
  logic fast_return_enable;  // switchback enable
  logic ring_osc_stop_select;  // resume-on-ring select
  logic [5:0] timer_speed_select;  // two bits per timer
  logic [3:0] activity;  // serial activity flags
  // divider in effect for the clock generator
  logic [1:0] eff_div;
  logic [10:0] sys_cnt;  // position inside system cycle
  // synchronisers
  logic [5:0] int_s1, int_s2, int_prev;
  logic [1:0] rx_s1, rx_s2, rx_prev;
  logic xtal_s1, xtal_s2, xtal_prev;
  // switchback bookkeeping
  logic [1:0] defer_cnt;  // instructions left with irqs held
  logic tx_pend;  // buffer loaded, waiting for next instr
  logic irq_sb, rx_sb, tx_sb, sb_now;
  logic wr_pmr, legal_wr;
  // clock source
  clkctl_pkg::clk_src_t src;
  logic [16:0] warm_cnt;
  logic ring_osc_active_flag;
  // tick generators
  logic [14:0] tick_cnt [7];
  logic [14:0] tick_per [7];
  logic [6:0] tick_hit;
  logic reduced_speed_mode;

  // oscillator cycles per system cycle, per setting
  function automatic logic [10:0] sys_ratio(input logic [1:0] d);
    sys_ratio = (d == `DIV_PMM) ? `PMM_RATIO : 11'h001;
  endfunction

  // timer tick period from its speed select
  function automatic logic [14:0] timer_per(input logic [1:0] s,
                                            input logic p);
    if (p) begin
      timer_per = (s == 2'h0) ? `TMR_PMM_SLOW_N : `TMR_PMM_FAST_N;
    end else if (s == 2'h0) begin
      timer_per = `TMR_SLOW_N;
    end else if (s == 2'h1) begin
      timer_per = `TMR_QUAD_N;
    end else begin
      timer_per = `TMR_FAST_N;
    end
  endfunction

  // two-flop synchronisers for pins
  always_ff @(posedge mclk) begin
    int_s1 <= ext_int_pin;
    int_s2 <= int_s1;
    rx_s1 <= rx_pin;
    rx_s2 <= rx_s1;
    xtal_s1 <= xtal_pin;
    xtal_s2 <= xtal_s1;
  end

  // previous synchronised values for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_prev <= 2'h3;
      xtal_prev <= 1'b0;
    end else begin
      rx_prev <= rx_s2;
      xtal_prev <= xtal_s2;
    end
  end

  // interrupt edges: sampled per system cycle, true edges in stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_prev <= 6'h00;
      ext_int_edge <= 6'h00;
    end else if (stop_mode) begin
      int_prev <= int_s2;  // see R21
      ext_int_edge <= int_prev & ~int_s2;
    end else if (sys_en) begin
      int_prev <= int_s2;  // see R21
      ext_int_edge <= int_prev & ~int_s2;
    end else begin
      ext_int_edge <= 6'h00;
    end
  end

  // serial activity flags, read-only copies
  always_ff @(posedge mclk) begin
    if (rst) begin
      activity <= 4'h0;  // see R24
    end else begin
      activity <= {serial.tx_active[1], serial.rx_active[1],
                   serial.tx_active[0], serial.rx_active[0]};
    end
  end

  // interrupt hold after an enable or priority write
  always_ff @(posedge mclk) begin
    if (rst) begin
      defer_cnt <= 2'h0;
    end else if (instr_end && ie_ip_write) begin
      defer_cnt <= 2'h1;  // see R15
    end else if (instr_end && defer_cnt != 2'h0) begin
      defer_cnt <= defer_cnt - 2'h1;
    end
  end

  // switchback sources; serial interrupt flags are not inputs
  // see R13
  always_comb begin
    irq_sb = irq_ack && (defer_cnt == 2'h0);  // see R9
    // start edge, address match irrelevant; see R11 see R17
    rx_sb = |(rx_prev & ~rx_s2 & serial.rx_enable);
    tx_sb = tx_pend && instr_end;  // see R16
    // see R10 see R23
    sb_now = fast_return_enable && (irq_sb || rx_sb || tx_sb);
  end

  // transmit buffer load waits for the next instruction
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_pend <= 1'b0;
    end else if (|serial.tx_load) begin
      tx_pend <= 1'b1;  // see R12
    end else if (instr_end) begin
      tx_pend <= 1'b0;
    end
  end

  // write legality of the divider field
  always_comb begin
    wr_pmr = bus.wr && (bus.addr == `POWER_MODE_REG_OFS);
    // see R2
    legal_wr = (divider == `DIV_ONE) ||
               (bus.wdata[`DIV_SEL_HI_BIT:`DIV_SEL_LO_BIT] == `DIV_ONE);
  end

  // divider select bits; switchback wins over a write
  always_ff @(posedge mclk) begin
    if (rst || reset_source) begin
      divider <= `DIV_RESET;  // see R22 see R10
    end else if (sb_now) begin
      divider <= `DIV_ONE;  // see R8
    end else if (wr_pmr && legal_wr) begin
      divider <= bus.wdata[`DIV_SEL_HI_BIT:`DIV_SEL_LO_BIT];
    end  // illegal writes keep the bits; see R3
  end

  // other software control bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      fast_return_enable <= 1'b0;  // see R23
      ring_osc_stop_select <= 1'b0;
      timer_speed_select <= `RATE_RESET;  // see R5
    end else if (bus.wr) begin
      if (bus.addr == `POWER_MODE_REG_OFS) begin
        fast_return_enable <= bus.wdata[`FAST_RETURN_BIT];
      end
      if (bus.addr == `EXTERNAL_FLAG_REG_OFS) begin
        ring_osc_stop_select <= bus.wdata[`RING_STOP_SEL_BIT];
      end
      if (bus.addr == `TIMER_RATE_CONTROL_REG_OFS) begin
        timer_speed_select <= bus.wdata[5:0];
      end
    end
  end

  // system cycle counter; new divider taken only at a boundary, except switchback, which loads divide-by-1 at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      eff_div <= `DIV_RESET;
      sys_cnt <= 11'h000;
    end else if (sb_now) begin
      eff_div <= `DIV_ONE;  // restart a full cycle; see R14
      sys_cnt <= 11'h000;
    end else if (sys_en) begin
      eff_div <= divider;  // see R25
      sys_cnt <= 11'h000;
    end else begin
      sys_cnt <= sys_cnt + 11'h001;
    end
  end

  // one enable per system cycle; see R1
  assign sys_en = (sys_cnt == sys_ratio(eff_div) - 11'h001);
  assign reduced_speed_mode = (eff_div == `DIV_PMM);

  // tick periods from mode and selects
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // see R5 see R6
      tick_per[i] = timer_per(timer_speed_select[2*i +: 2], reduced_speed_mode);
    end
    // timer 2 ignores its select in reduced speed
    if (reduced_speed_mode) begin
      tick_per[2] = `T2_PMM_N;  // see R6
    end
    for (int p = 0; p < 2; p++) begin
      // see R7
      if (reduced_speed_mode) begin
        tick_per[3+p] = serial.multiprocessor_enable[p] ?
                        `SM0_PMM_FAST_N : `SM0_PMM_SLOW_N;
        tick_per[5+p] = serial.baud_doubler ?
                        `SM2_PMM_FAST_N : `SM2_PMM_SLOW_N;
      end else begin
        tick_per[3+p] = serial.multiprocessor_enable[p] ?
                        `SM0_FAST_N : `SM0_SLOW_N;
        tick_per[5+p] = serial.baud_doubler ?
                        `SM2_FAST_N : `SM2_SLOW_N;
      end
    end
  end

  // tick counters in oscillator cycles
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 7; i++) begin
      if (rst || tick_hit[i]) begin
        tick_cnt[i] <= 15'h0000;
      end else begin
        tick_cnt[i] <= tick_cnt[i] + 15'h0001;
      end
    end
  end

  // terminal counts; a shrunk period ends at once
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      tick_hit[i] = (tick_cnt[i] >= tick_per[i] - 15'h0001);
    end
  end

  // registered tick outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      ticks <= '0;
    end else begin
      ticks.timer_tick <= tick_hit[2:0];
      ticks.mode0_tick <= tick_hit[4:3];
      ticks.mode2_tick <= tick_hit[6:5];
    end
  end

  // clock source: ring on resume, crystal after warm-up
  always_ff @(posedge mclk) begin
    if (rst) begin
      src <= clkctl_pkg::SRC_XTAL;  // see R20
      warm_cnt <= 17'h00000;
    end else begin
      unique case (src)
        clkctl_pkg::SRC_XTAL: begin
          if (stop_exit && ring_osc_stop_select) begin
            src <= clkctl_pkg::SRC_RING;  // see R18
            warm_cnt <= 17'h00000;
          end
        end
        clkctl_pkg::SRC_RING: begin
          // count crystal edges while running on the ring
          if (xtal_s2 && !xtal_prev) begin
            if (warm_cnt == 17'(WARMUP - 1)) begin
              src <= clkctl_pkg::SRC_XTAL;  // see R18
            end
            warm_cnt <= warm_cnt + 17'h00001;
          end
        end
      endcase
    end
  end

  assign ring_osc_active_flag = (src == clkctl_pkg::SRC_RING);
  assign ring_osc_select = ring_osc_active_flag;

  // read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `POWER_MODE_REG_OFS:
          rdata <= {divider, fast_return_enable, 5'h00};
        `STATUS_REG_OFS:
          rdata <= {4'h0, activity};  // see R24
        `EXTERNAL_FLAG_REG_OFS:
          // see R19
          rdata <= {5'h00, ring_osc_active_flag,
                    ring_osc_stop_select, 1'b0};
        `TIMER_RATE_CONTROL_REG_OFS:
          rdata <= {2'h0, timer_speed_select};
        default:
          rdata <= 8'h00;  // unmapped reads zero
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // assertions
  sequence s_rx_start;
    fast_return_enable && rx_sb;
  endsequence

  sequence s_back_at_one;
    divider == `DIV_ONE && eff_div == `DIV_ONE ##1 sys_en;
  endsequence

  property p_reset_state;
    @(posedge mclk) rst |=> divider == `DIV_ONE && !ring_osc_select
      && !fast_return_enable && activity == 4'h0;
  endproperty
  a_reset_state: assert property (p_reset_state)  // see R22
    else $error("reset state wrong");

  property p_illegal_ignored;
    @(posedge mclk) disable iff (rst)
      wr_pmr && !legal_wr && !sb_now && !reset_source
      |=> $stable(divider);
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored)  // see R3
    else $error("illegal divider write took effect");

  property p_rx_switchback;
    @(posedge mclk) disable iff (rst)
      s_rx_start |=> s_back_at_one;
  endproperty
  a_rx_switchback: assert property (p_rx_switchback)  // see R16
    else $error("receive switchback late");

  property p_no_switchback;
    @(posedge mclk) disable iff (rst)
      !fast_return_enable && !wr_pmr && !reset_source
      |=> $stable(divider);
  endproperty
  a_no_switchback: assert property (p_no_switchback)  // see R23
    else $error("divider moved without enable");

  property p_tx_switchback;
    @(posedge mclk) disable iff (rst)
      fast_return_enable && tx_pend && instr_end
      |=> divider == `DIV_ONE;
  endproperty
  a_tx_switchback: assert property (p_tx_switchback)  // see R12
    else $error("transmit switchback missing");

  property p_defer;
    @(posedge mclk) disable iff (rst)
      instr_end && ie_ip_write ##1 (!instr_end)[*1]
      |-> !irq_sb;
  endproperty
  a_defer: assert property (p_defer)  // see R15
    else $error("interrupt not deferred");

  property p_pmm_gap;
    @(posedge mclk) disable iff (rst)
      sys_en && !sb_now && divider == `DIV_PMM && eff_div == `DIV_PMM
      |=> (!sys_en || eff_div != `DIV_PMM) [*8];
  endproperty
  a_pmm_gap: assert property (p_pmm_gap)  // see R1
    else $error("reduced-speed cycle too short");

  property p_boundary;
    @(posedge mclk) disable iff (rst)
      !sys_en && !sb_now |=> $stable(eff_div);
  endproperty
  a_boundary: assert property (p_boundary)  // see R25
    else $error("divider changed mid cycle");

  property p_ring_resume;
    @(posedge mclk) disable iff (rst)
      stop_exit && ring_osc_stop_select && !ring_osc_select
      |=> ring_osc_select && warm_cnt == 17'h00000;
  endproperty
  a_ring_resume: assert property (p_ring_resume)  // see R18
    else $error("no ring resume");

endmodule
`default_nettype wire

// ===== clkctl_defs.svh
// register offsets, field positions, reset values and counts for clkctl
`ifndef CLKCTL_DEFS_SVH
`define CLKCTL_DEFS_SVH
// register indices on the plain register port
`define POWER_MODE_REG_OFS 8'h00
`define STATUS_REG_OFS 8'h01
`define EXTERNAL_FLAG_REG_OFS 8'h02
`define TIMER_RATE_CONTROL_REG_OFS 8'h03
// power mode register fields
`define DIV_SEL_HI_BIT 7
`define DIV_SEL_LO_BIT 6
`define FAST_RETURN_BIT 5
// external flag register fields
`define RING_ACTIVE_BIT 2
`define RING_STOP_SEL_BIT 1
// divider codes
`define DIV_MULT 2'h0
`define DIV_RSVD 2'h1
`define DIV_ONE 2'h2
`define DIV_PMM 2'h3
// reset values
`define DIV_RESET 2'h2
`define RATE_RESET 6'h00
// oscillator cycles per system cycle in reduced-speed mode
`define PMM_RATIO 11'h400
// oscillator cycles per tick, divide-by-1 setting
`define TMR_SLOW_N 15'h000C
`define TMR_QUAD_N 15'h0004
`define TMR_FAST_N 15'h0001
`define T2_N 15'h0002
`define SM0_SLOW_N 15'h000C
`define SM0_FAST_N 15'h0004
`define SM2_SLOW_N 15'h0040
`define SM2_FAST_N 15'h0020
// oscillator cycles per tick, divide-by-1024 setting
`define TMR_PMM_SLOW_N 15'h0C00
`define TMR_PMM_FAST_N 15'h0400
`define T2_PMM_N 15'h0800
`define SM0_PMM_SLOW_N 15'h0C00
`define SM0_PMM_FAST_N 15'h0400
`define SM2_PMM_SLOW_N 15'h3FDC
`define SM2_PMM_FAST_N 15'h2000
// crystal warm-up after stop, external-source clocks
`define WARMUP_CLOCKS 65536
`endif

// ===== clkctl_pkg.sv
// types shared by the clock controller
`default_nettype none
package clkctl_pkg;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // serial side information, per port except the shared baud doubler
  typedef struct packed {
    logic [1:0] rx_enable;
    logic [1:0] tx_load;
    logic [1:0] tx_active;
    logic [1:0] rx_active;
    logic [1:0] multiprocessor_enable;
    logic baud_doubler;
  } serial_info_t;
  // time-base enables toward timers and serial ports
  typedef struct packed {
    logic [2:0] timer_tick;
    logic [1:0] mode0_tick;
    logic [1:0] mode2_tick;
  } tick_t;
  // clock source state, one-hot
  typedef enum logic [1:0] {
    SRC_XTAL = 2'b01,
    SRC_RING = 2'b10
  } clk_src_t;
endpackage
`default_nettype wire

// ===== clock_divider_switchback_ctrl_tb_top.sv
// self-checking bench for the clock divider and switchback controller
`default_nettype none
module clock_divider_switchback_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WARM = 8; // shortened crystal warm-up
  logic mclk;
  logic rst;
  clkctl_pkg::reg_req_t bus;
  logic [7:0] rdata;
  logic [5:0] ext_int_pin;
  logic irq_ack;
  logic ie_ip_write;
  logic instr_end;
  logic [1:0] rx_pin;
  clkctl_pkg::serial_info_t serial;
  logic reset_source;
  logic stop_mode;
  logic stop_exit;
  logic xtal_pin;
  logic sys_en;
  clkctl_pkg::tick_t ticks;
  logic [5:0] ext_int_edge;
  logic ring_osc_select;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  logic [7:0] wr_seq [10] = '{8'hC0, 8'h00, 8'h80, 8'h00, 8'hE0, 8'h80,
    8'h40, 8'hC0, 8'h80, 8'h80};
  logic [7:0] rd_seq [10] = '{8'hC0, 8'hC0, 8'h80, 8'h00, 8'h20, 8'h80,
    8'h40, 8'h40, 8'h80, 8'h80};

  // device under test, warm-up shortened
  clock_divider_switchback_ctrl #(.WARMUP(WARM)) DUT (
    .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .ext_int_pin(ext_int_pin), .irq_ack(irq_ack),
    .ie_ip_write(ie_ip_write), .instr_end(instr_end), .rx_pin(rx_pin),
    .serial(serial), .reset_source(reset_source), .stop_mode(stop_mode),
    .stop_exit(stop_exit), .xtal_pin(xtal_pin), .sys_en(sys_en),
    .ticks(ticks), .ext_int_edge(ext_int_edge),
    .ring_osc_select(ring_osc_select)
  );

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // register, flag and count comparisons
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk_reg(rdata, exp);
    @(posedge mclk);
  endtask

  // one-cycle pulse on a chosen control input
  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0: irq_ack <= 1'b1;
      1: instr_end <= 1'b1;
      2: stop_exit <= 1'b1;
      3: serial.tx_load <= 2'b01;
      default: reset_source <= 1'b1;
    endcase
    @(posedge mclk);
    irq_ack <= 1'b0;
    instr_end <= 1'b0;
    stop_exit <= 1'b0;
    serial.tx_load <= 2'b00;
    reset_source <= 1'b0;
  endtask

  // observed outputs by index
  function automatic logic probe(input int k);
    case (k)
      0: return sys_en;
      1: return ticks.timer_tick[0];
      2: return ring_osc_select;
      3: return ext_int_edge[2];
      4: return ticks.timer_tick[2];
      default: return ticks.mode0_tick[0];
    endcase
  endfunction

  // bounded wait, cycles counted until the value shows
  task automatic await(input int k, input logic v, input int lim,
                       output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      @(negedge mclk);
      cnt++;
      if (probe(k) === v) return;
    end
    chk_cnt(cnt + 1, cnt); // timeout counts as mismatch
    close_out();
  endtask
  // period between two pulses, first partial period and first full period skipped
  task automatic period(input int k, input int exp);
    await(k, 1'b1, 4000, n);
    await(k, 1'b1, 4000, n);
    await(k, 1'b1, 4000, n);
    chk_cnt(n, exp);
  endtask

  // one rising and falling crystal edge
  task automatic xedge();
    @(posedge mclk);
    xtal_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    xtal_pin <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // run limit
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    bus = '0;
    ext_int_pin = 6'h3F;
    irq_ack = 1'b0;
    ie_ip_write = 1'b0;
    instr_end = 1'b0;
    rx_pin = 2'h3;
    serial = '0;
    reset_source = 1'b0;
    stop_mode = 1'b0;
    stop_exit = 1'b0;
    xtal_pin = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // reset values, read-only and unmapped places
    rdchk(8'h00, 8'h80);
    rdchk(8'h03, 8'h00);
    wr(8'h01, 8'hFF);
    rdchk(8'h01, 8'h00);
    wr(8'h02, 8'h04);
    rdchk(8'h02, 8'h00);
    rdchk(8'h10, 8'h00);
    $display("test reset done");
    // legal and illegal divider transitions
    foreach (wr_seq[i]) begin
      wr(8'h00, wr_seq[i]);
      rdchk(8'h00, rd_seq[i]);
    end
    $display("test divider done");
    // time bases at divide-by-1 and reduced speed
    period(1, 12);
    wr(8'h03, 8'h01);
    period(1, 4);
    wr(8'h03, 8'h02);
    period(1, 1);
    wr(8'h03, 8'h00);
    rdchk(8'h01, 8'h00);
    wr(8'h00, 8'hC0);
    period(0, 1024);
    period(1, 3072);
    wr(8'h03, 8'h01);
    period(1, 1024);
    period(4, 2048);
    @(posedge mclk);
    serial.multiprocessor_enable <= 2'b01;
    period(5, 1024);
    wr(8'h03, 8'h00);
    $display("test rates done");
    // switchback disabled leaves divider alone
    serial.rx_enable <= 2'b11;
    pulse(0);
    rx_pin[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    rx_pin[0] <= 1'b1;
    rdchk(8'h00, 8'hC0);
    // acknowledged interrupt
    wr(8'h00, 8'hE0);
    pulse(0);
    rdchk(8'h00, 8'hA0);
    // enable/priority write defers interrupts one instruction
    wr(8'h00, 8'hE0);
    ie_ip_write <= 1'b1;
    pulse(1);
    ie_ip_write <= 1'b0;
    pulse(0);
    rdchk(8'h00, 8'hE0);
    pulse(1);
    pulse(0);
    rdchk(8'h00, 8'hA0);
    $display("test interrupt done");
    // start bit ignored with receiver off, honoured with it on
    wr(8'h00, 8'hE0);
    serial.rx_enable <= 2'b01;
    serial.multiprocessor_enable <= 2'b10;
    rx_pin[1] <= 1'b0;
    repeat (8) @(posedge mclk);
    rx_pin[1] <= 1'b1;
    rdchk(8'h00, 8'hE0);
    repeat (4) @(posedge mclk);
    serial.rx_enable <= 2'b10;
    rx_pin[1] <= 1'b0;
    repeat (8) @(posedge mclk);
    rx_pin[1] <= 1'b1;
    rdchk(8'h00, 8'hA0);
    // transmit load switches back at next instruction
    wr(8'h00, 8'hE0);
    pulse(3);
    rdchk(8'h00, 8'hE0);
    pulse(1);
    rdchk(8'h00, 8'hA0);
    // reset sources force divide-by-1
    wr(8'h00, 8'hE0);
    pulse(4);
    rdchk(8'h00, 8'hA0);
    $display("test switchback done");
    // serial activity flags
    serial.tx_active <= 2'b10;
    serial.rx_active <= 2'b01;
    repeat (3) @(posedge mclk);
    rdchk(8'h01, 8'h09);
    serial.tx_active <= 2'b00;
    serial.rx_active <= 2'b00;
    $display("test status done");
    // stop resume on ring oscillator, then crystal after warm-up
    wr(8'h02, 8'h02);
    rdchk(8'h02, 8'h02);
    stop_mode <= 1'b1;
    @(posedge mclk);
    ext_int_pin[2] <= 1'b0;
    await(3, 1'b1, 6, n);
    @(posedge mclk);
    stop_mode <= 1'b0;
    pulse(2);
    await(2, 1'b1, 3, n);
    rdchk(8'h02, 8'h06);
    repeat (WARM - 1) xedge();
    repeat (6) @(posedge mclk);
    chk_reg({7'h00, ring_osc_select}, 8'h01);
    xedge();
    await(2, 1'b0, 10, n);
    rdchk(8'h02, 8'h02);
    $display("test ring done");
    close_out();
  end
endmodule
`default_nettype wire
